// ==== fsp_defines.svh ====
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Width of temperature, threshold and ramp codes
`define FSP_CODE_W          8
// Ramp limits as codes
`define FSP_RAMP_FLOOR      8'h40
`define FSP_RAMP_CEIL       8'hC0
`define FSP_RAMP_SPAN       (`FSP_RAMP_CEIL - `FSP_RAMP_FLOOR)

// Clock rate and nominal pulse rate
`define FSP_MCLK_HZ         250000000
`define FSP_PWM_HZ          30
`define FSP_PERIOD_CYC      (`FSP_MCLK_HZ / `FSP_PWM_HZ)
`define FSP_STEP_CYC        (`FSP_PERIOD_CYC / `FSP_RAMP_SPAN)

// Supervision counts, in PWM periods or tach pulses
`define FSP_CNT_W           6
`define FSP_START_PERIODS   6'h20
`define FSP_DIAG_PERIODS    6'h03
`define FSP_MISS_PERIODS    6'h20
`define FSP_WINDOW_PERIODS  6'h20
`define FSP_RECOVER_PULSES  6'h10

// Step length input width
`define FSP_STEP_W          24

`endif

// ==== fsp_pkg.sv ====
package fsp_pkg;
`include "fsp_defines.svh"

   typedef logic [`FSP_CODE_W-1:0] fsp_code_t;
   typedef logic [`FSP_CNT_W-1:0]  fsp_cnt_t;

   // Analog levels delivered as codes
   typedef struct packed {
      fsp_code_t temp_control_in;
      fsp_code_t autoshutdown_threshold;
      fsp_code_t autoshutdown_hysteresis;
   } fsp_levels_t;

   // Pin-side flags, in sync-vector order
   typedef struct packed {
      logic release_level;
      logic shutdown_level;
      logic fan_pulse_in;
   } fsp_pins_t;

   // Controller modes
   typedef enum logic [6:0] {
      ST_SHDN   = 7'h01,
      ST_ASHDN  = 7'h02,
      ST_START1 = 7'h04,
      ST_START2 = 7'h08,
      ST_RUN    = 7'h10,
      ST_DIAG   = 7'h20,
      ST_FAULT  = 7'h40
   } fsp_state_t;

endpackage

// ==== fsp_ramp.sv ====
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_ramp
   import fsp_pkg::*;
#(
   parameter int STEP_CYC = `FSP_STEP_CYC
) (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  resetn,
   // Step length, zero selects the default
   input  wire logic [`FSP_STEP_W-1:0] ramp_timing_cap,
   // Ramp value and period start
   output fsp_code_t                  ramp_q,
   output logic                       period_tick_q
);

   localparam logic [`FSP_STEP_W-1:0] STEP_DEF = `FSP_STEP_W'(STEP_CYC - 1);

   logic [`FSP_STEP_W-1:0] pres_q;
   logic [`FSP_STEP_W-1:0] step_last;

   // Refuse a step length the prescaler cannot hold
   if (STEP_CYC < 1 || STEP_CYC >= (1 << `FSP_STEP_W)) begin : g_bad_step
      $error("fsp_ramp: STEP_CYC out of range");
   end

   // Selected step length
   assign step_last = (ramp_timing_cap == '0) ? STEP_DEF : ramp_timing_cap - `FSP_STEP_W'(1);

   // Prescaler per ramp step
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pres_q <= '0;
      end else if (pres_q >= step_last) begin
         pres_q <= '0;
      end else begin
         pres_q <= pres_q + `FSP_STEP_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ramp_q        <= `FSP_RAMP_FLOOR;
         period_tick_q <= 1'b0;
      end else begin
         period_tick_q <= 1'b0;
         if (pres_q >= step_last) begin
            if (ramp_q >= `FSP_RAMP_CEIL - `FSP_CODE_W'(1)) begin
               ramp_q        <= `FSP_RAMP_FLOOR;
               period_tick_q <= 1'b1;
            end else begin
               ramp_q <= ramp_q + `FSP_CODE_W'(1);
            end
         end
      end
   end

endmodule

// ==== fsp_ctrl.sv ====
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_ctrl
   import fsp_pkg::*;
#(
   parameter int PERIOD_CYC = `FSP_PERIOD_CYC,
   parameter int STEP_CYC   = PERIOD_CYC / `FSP_RAMP_SPAN
) (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   resetn,
   // Levels and ramp step length
   input  fsp_levels_t                 levels_in,
   input  wire logic [`FSP_STEP_W-1:0] ramp_timing_cap,
   // Asynchronous pin flags
   input  fsp_pins_t                   pins_in,
   // Fan drive
   output logic                        pwm_drive_out,
   // Open-drain fault flag
   output logic                        fan_fault_n_out,
   output logic                        fan_fault_n_oe_n,
   // Mode for observation
   output fsp_state_t                  state_out
);

   fsp_state_t state_q;
   fsp_state_t state_d;
   fsp_code_t  ramp;
   logic       tick;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;
   logic [2:0] stab_q;
   logic [2:0] stab_prev_q;
   logic       tach_edge;
   logic       shdn_s;
   logic       rel_s;
   logic       below_thr;
   logic       above_hys;
   logic       chg;
   logic       seen_any;
   fsp_cnt_t   per_cnt_q;
   fsp_cnt_t   miss_cnt_q;
   fsp_cnt_t   tach_cnt_q;
   logic       pulse_seen_q;
   logic       drive_d;

   // Refuse a period shorter than one ramp sweep
   if (PERIOD_CYC < `FSP_RAMP_SPAN || STEP_CYC < 1) begin : g_bad_period
      $error("fsp_ctrl: PERIOD_CYC too small for ramp span");
   end

   fsp_ramp #(
      .STEP_CYC        (STEP_CYC)
   ) fsp_ramp_i (
      .mclk            (mclk),
      .resetn          (resetn),
      .ramp_timing_cap (ramp_timing_cap),
      .ramp_q          (ramp),
      .period_tick_q   (tick)
   );

   generate
      for (genvar i = 0; i < 3; i++) begin : g_sync
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               sync1_q[i]     <= 1'b0;
               sync2_q[i]     <= 1'b0;
               sync3_q[i]     <= 1'b0;
               stab_q[i]      <= 1'b0;
               stab_prev_q[i] <= 1'b0;
            end else begin
               sync1_q[i]     <= pins_in[i];
               sync2_q[i]     <= sync1_q[i];
               sync3_q[i]     <= sync2_q[i];
               stab_prev_q[i] <= stab_q[i];
               if (sync2_q[i] == sync3_q[i]) begin
                  stab_q[i] <= sync3_q[i];
               end
            end
         end
      end
   endgenerate

   // Decoded flags and level compares
   assign tach_edge = stab_q[0] & ~stab_prev_q[0];
   assign shdn_s    = stab_q[1];
   assign rel_s     = stab_q[2];
   assign below_thr = levels_in.temp_control_in < levels_in.autoshutdown_threshold;
   assign above_hys = {1'b0, levels_in.temp_control_in} >
                      ({1'b0, levels_in.autoshutdown_threshold} + {1'b0, levels_in.autoshutdown_hysteresis});
   assign seen_any  = pulse_seen_q | tach_edge;
   assign chg       = (state_d != state_q);

   // Mode sequencing
   always_comb begin
      state_d = state_q;
      if (shdn_s) begin
         state_d = ST_SHDN;
      end else begin
         case (state_q)
            ST_SHDN: begin
               if (rel_s && !below_thr && levels_in.temp_control_in != levels_in.autoshutdown_threshold) begin
                  state_d = ST_START1;
               end
            end
            ST_ASHDN: begin
               if (above_hys) begin
                  state_d = ST_START1;
               end
            end
            ST_START1: begin
               if (below_thr) begin
                  state_d = ST_ASHDN;
               end else if (tick && per_cnt_q == `FSP_START_PERIODS - `FSP_CNT_W'(1)) begin
                  state_d = seen_any ? ST_RUN : ST_START2;
               end
            end
            ST_START2: begin
               if (below_thr) begin
                  state_d = ST_ASHDN;
               end else if (tick && per_cnt_q == `FSP_START_PERIODS - `FSP_CNT_W'(1)) begin
                  state_d = seen_any ? ST_RUN : ST_FAULT;
               end
            end
            ST_RUN: begin
               if (below_thr) begin
                  state_d = ST_ASHDN;
               end else if (tick && !tach_edge && miss_cnt_q == `FSP_MISS_PERIODS - `FSP_CNT_W'(1)) begin
                  state_d = ST_DIAG;
               end
            end
            ST_DIAG: begin
               if (below_thr) begin
                  state_d = ST_ASHDN;
               end else if (tick && per_cnt_q == `FSP_DIAG_PERIODS - `FSP_CNT_W'(1)) begin
                  state_d = seen_any ? ST_RUN : ST_START2;
               end
            end
            ST_FAULT: begin
               if (tach_edge && tach_cnt_q == `FSP_RECOVER_PULSES - `FSP_CNT_W'(1)) begin
                  state_d = below_thr ? ST_ASHDN : ST_RUN;
               end
            end
            default: begin
               state_d = ST_START1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_START1;
      end else begin
         state_q <= state_d;
      end
   end

   // Period counter per mode, wraps as fault window
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         per_cnt_q <= '0;
      end else if (chg) begin
         per_cnt_q <= '0;
      end else if (tick) begin
         if (per_cnt_q == `FSP_WINDOW_PERIODS - `FSP_CNT_W'(1)) begin
            per_cnt_q <= '0;
         end else begin
            per_cnt_q <= per_cnt_q + `FSP_CNT_W'(1);
         end
      end
   end

   // Tach seen in interval, set wins
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pulse_seen_q <= 1'b0;
      end else begin
         pulse_seen_q <= tach_edge | (pulse_seen_q & ~chg);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         miss_cnt_q <= '0;
      end else if (tach_edge || chg) begin
         miss_cnt_q <= '0;
      end else if (tick && miss_cnt_q != `FSP_MISS_PERIODS) begin
         miss_cnt_q <= miss_cnt_q + `FSP_CNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tach_cnt_q <= '0;
      end else if (chg) begin
         tach_cnt_q <= '0;
      end else if (tick && per_cnt_q == `FSP_WINDOW_PERIODS - `FSP_CNT_W'(1)) begin
         tach_cnt_q <= tach_edge ? `FSP_CNT_W'(1) : '0;
      end else if (tach_edge && tach_cnt_q != `FSP_RECOVER_PULSES) begin
         tach_cnt_q <= tach_cnt_q + `FSP_CNT_W'(1);
      end
   end

   always_comb begin
      drive_d = 1'b0;
      case (state_q)
         ST_SHDN, ST_ASHDN: drive_d = 1'b0;
         ST_START1, ST_START2, ST_DIAG, ST_FAULT: drive_d = 1'b1;
         ST_RUN: drive_d = levels_in.temp_control_in > ramp;
         default: drive_d = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pwm_drive_out <= 1'b0;
      end else begin
         pwm_drive_out <= drive_d;
      end
   end

   // fault flag pulls low only in fault
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fan_fault_n_out  <= 1'b0;
         fan_fault_n_oe_n <= 1'b1;
         state_out        <= ST_START1;
      end else begin
         fan_fault_n_out  <= 1'b0;
         fan_fault_n_oe_n <= (state_q != ST_FAULT);
         state_out        <= state_q;
      end
   end

   // Start interval ending with and without tach
   sequence seq_start_end_seen;
      state_q == ST_START1 && tick && per_cnt_q == `FSP_START_PERIODS - `FSP_CNT_W'(1)
         && seen_any && !shdn_s && !below_thr;
   endsequence

   sequence seq_start2_end_miss;
      state_q == ST_START2 && tick && per_cnt_q == `FSP_START_PERIODS - `FSP_CNT_W'(1)
         && !seen_any && !shdn_s && !below_thr;
   endsequence

   AST_SHDN_LOW: assert property (@(posedge mclk) disable iff (!resetn)
      shdn_s |=> state_q == ST_SHDN ##1 (!pwm_drive_out && fan_fault_n_oe_n))
      else $error("shutdown did not force drive low");

   AST_FULL_ON: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q inside {ST_START1, ST_START2, ST_DIAG, ST_FAULT}) |=> pwm_drive_out)
      else $error("drive not full on in start, diagnostic or fault");

   AST_RUN_COMPARE: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == ST_RUN) |=> pwm_drive_out == ($past(levels_in.temp_control_in) > $past(ramp)))
      else $error("run drive does not follow ramp compare");

   AST_START_TO_RUN: assert property (@(posedge mclk) disable iff (!resetn)
      seq_start_end_seen |=> state_q == ST_RUN)
      else $error("start with tach did not enter run");

   AST_FAULT_ENTRY: assert property (@(posedge mclk) disable iff (!resetn)
      seq_start2_end_miss |=> ##1 !fan_fault_n_oe_n)
      else $error("second missed start did not assert fault");

   AST_FAULT_ONLY: assert property (@(posedge mclk) disable iff (!resetn)
      !fan_fault_n_oe_n |-> $past(state_q) == ST_FAULT)
      else $error("fault flag driven outside fault");

   AST_MISS_CLEAR: assert property (@(posedge mclk) disable iff (!resetn)
      tach_edge |=> miss_cnt_q == '0)
      else $error("tach pulse did not clear miss counter");

   AST_RAMP_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
      (ramp >= `FSP_RAMP_FLOOR && ramp < `FSP_RAMP_CEIL)
         and (tick |-> $past(ramp) == `FSP_RAMP_CEIL - 8'h01))
      else $error("ramp outside floor to ceiling");

   AST_ASHDN_ENTRY: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == ST_RUN && below_thr && !shdn_s) |=> state_q == ST_ASHDN ##1 !pwm_drive_out)
      else $error("auto-shutdown not entered below threshold");

   AST_FAULT_RECOVER: assert property (@(posedge mclk) disable iff (!resetn)
      (state_q == ST_FAULT && tach_edge && tach_cnt_q == `FSP_RECOVER_PULSES - 6'h01 && !shdn_s)
         |=> state_q inside {ST_RUN, ST_ASHDN})
      else $error("fault did not recover on sixteenth pulse");

endmodule

// ==== fsp_fan_model.sv ====
`timescale 1ns/1ps
module fsp_fan_model #(
   parameter int GAP = 40
) (
   // Clock
   input  wire logic mclk,
   // Drive and fan health
   input  wire logic drive,
   input  wire logic alive,
   // Tach pulse line
   output logic      tach
);
   int   cnt   = 0;
   logic spun  = 1'b0;

   initial tach = 1'b0;

   always @(posedge mclk) begin
      spun <= #1 alive && (spun || drive);
   end

   // Tach pulses, four cycles wide, only while spinning
   always @(posedge mclk) begin
      cnt  <= #1 (cnt + 1) % GAP;
      tach <= #1 spun && (cnt < 4);
   end
endmodule

// ==== tb_fan_speed_pwm_controller.sv ====
`timescale 1ns/1ps
module tb_fan_speed_pwm_controller;
   import fsp_pkg::*;

   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   fsp_code_t   temp = 8'h80;
   fsp_code_t   thr = 8'h20;
   fsp_code_t   hys = 8'h08;
   logic [23:0] cap = 24'h000000;
   logic        shd = 1'b0;
   logic        rel = 1'b0;
   logic        alive = 1'b1;
   logic        tach;
   logic        drv;
   logic        fo;
   logic        oe_n;
   fsp_state_t  st;
   int          mismatches = 0;
   int          n_tests = 0;
   logic [31:0] seed = 32'h4246B665;

   // Clock, 4 ns period
   initial forever #2 mclk = ~mclk;

   fsp_ctrl #(.PERIOD_CYC(256), .STEP_CYC(2)) fsp_ctrl_i (
      .mclk            (mclk),
      .resetn          (resetn),
      .levels_in       ({temp, thr, hys}),
      .ramp_timing_cap (cap),
      .pins_in         ({rel, shd, tach}),
      .pwm_drive_out   (drv),
      .fan_fault_n_out (fo),
      .fan_fault_n_oe_n(oe_n),
      .state_out       (st)
   );

   fsp_fan_model fsp_fan_model_i (
      .mclk (mclk),
      .drive(drv),
      .alive(alive),
      .tach (tach)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   // High cycles expected in one 256-cycle period
   function automatic int exp_hi(input fsp_code_t t);
      if (t <= 8'h40) return 0;
      if (t >= 8'hC0) return 256;
      return (int'(t) - 64) * 2;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         mismatches++;
      end
   endtask

   // Waits for a mode, counting cycles and drive-low cycles before it
   task automatic wait_st(input fsp_state_t s, input int lim, output int n, output int lo);
      n = 0;
      lo = 0;
      while (st !== s && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
         if (drv !== 1'b1 && st !== s) lo++;
      end
      chk("mode", s, st);
   endtask

   task automatic clk(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   task automatic stop_test;
      $display("Checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (100000) @(posedge mclk);
      mismatches++;
      stop_test();
   end

   initial begin
      int        n;
      int        lo;
      int        hi;
      int        ri;
      int        e;
      logic      pv;
      fsp_code_t t;
      clk(20);
      resetn = 1'b1;
      clk(2);
      wait_st(ST_RUN, 8500, n, lo);
      chk("start len", 1, n >= 7900 && n <= 8250);
      chk("start low", 0, lo);
      cap = 24'h000002;
      // Duty corners and random levels
      for (int i = 0; i < 7; i++) begin
         seed = xs(seed);
         t = (i == 0) ? 8'h40 : (i == 1) ? 8'hC0 : (i == 2) ? 8'hFF : (i == 3) ? 8'h30 : 8'h41 + 8'(seed % 127);
         // Last pass halves the step to show the period follows it
         cap = (i == 6) ? 24'h000001 : 24'h000002;
         temp = t;
         clk(512);
         hi = 0;
         ri = 0;
         pv = drv;
         repeat (1024) begin
            clk(1);
            if (drv === 1'b1) hi++;
            if (drv === 1'b1 && pv !== 1'b1) ri++;
            pv = drv;
         end
         e = exp_hi(t);
         chk("duty", 4 * e, hi);
         chk("rises", (e > 0 && e < 256) ? 1024 / (128 * int'(cap)) : 0, ri);
      end
      // Stalled fan, nominal step restored
      cap = 24'h000002;
      temp = 8'h80;
      alive = 1'b0;
      wait_st(ST_DIAG, 8800, n, lo);
      chk("miss len", 1, n >= 7600 && n <= 8500);
      wait_st(ST_START2, 900, n, lo);
      chk("diag len", 1, n >= 700 && n <= 800);
      chk("diag low", 0, lo);
      wait_st(ST_FAULT, 8500, n, lo);
      chk("retry len", 1, n >= 7900 && n <= 8250);
      chk("retry low", 0, lo);
      clk(3);
      chk("fault flag", 0, oe_n);
      chk("flag data", 0, fo);
      alive = 1'b1;
      wait_st(ST_RUN, 8500, n, lo);
      chk("fault low", 0, lo);
      clk(3);
      chk("flag free", 1, oe_n);
      // Auto-shutdown with hysteresis
      thr = 8'h50;
      hys = 8'h10;
      temp = 8'h48;
      wait_st(ST_ASHDN, 20, n, lo);
      clk(2);
      chk("ashdn drive", 0, drv);
      chk("ashdn flag", 1, oe_n);
      alive = 1'b0;
      temp = 8'h58;
      clk(50);
      chk("hysteresis", ST_ASHDN, st);
      temp = 8'h70;
      wait_st(ST_START1, 20, n, lo);
      wait_st(ST_START2, 8500, n, lo);
      chk("start2 len", 1, n >= 7900 && n <= 8250);
      chk("start2 low", 0, lo);
      alive = 1'b1;
      wait_st(ST_RUN, 8500, n, lo);
      // Remote shutdown and release
      shd = 1'b1;
      wait_st(ST_SHDN, 20, n, lo);
      clk(2);
      chk("shdn drive", 0, drv);
      chk("shdn flag", 1, oe_n);
      // Release refused while below threshold
      temp = 8'h48;
      shd = 1'b0;
      rel = 1'b1;
      clk(20);
      chk("rel below thr", ST_SHDN, st);
      temp = 8'h70;
      wait_st(ST_START1, 20, n, lo);
      wait_st(ST_RUN, 8500, n, lo);
      chk("rel low", 0, lo);
      stop_test();
   end
endmodule
